// ---- logic/rx_crc32_acc.sv ----
// Running frame check accumulator, up to eight bytes per cycle.
// Assumes byte 0 sits in the top lane and a synchronised reset.
`timescale 1ns/1ps
`default_nettype none
module rx_crc32_acc (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [rx_mac_pkg::WORD_W-1:0] i_word,
  input wire logic [3:0] i_nbytes,
  output logic [31:0] o_crc_next
);
  import rx_mac_pkg::*;

  typedef struct packed {
    logic [31:0] crc;
  } crc_state_t;

  crc_state_t q;
  crc_state_t d;
  logic [31:0] nx;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ b[i]) ? CRC_POLY : 32'h0);
    end
    return r;
  endfunction

  always_comb begin
    nx = q.crc;
    for (int k = 0; k < LANES; k++) begin
      if (4'(k) < i_nbytes) begin
        nx = crc_byte(nx, i_word[WORD_W-1-8*k -: 8]);
      end
    end
    d = q;
    if (i_clear) begin
      d.crc = CRC_INIT;
    end else if (i_en) begin
      d.crc = nx;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_crc_next = nx;
endmodule
`default_nettype wire

// ---- logic/rx_mac_client_out.sv ----
// Receive MAC client output: frame marks, empty count, errors, status.
// Assumes a decoded 64-bit lane stream on the core clock, top lane first.
// Summary of operation
// - First mark on word with first byte
// - Last mark on last data or FCS byte
// - Unused low lanes counted when last
// - Six error bits valid only with last
// - Short payload against length field flagged
// - Frame above programmed maximum flagged
// - Frame below 64 bytes flagged
// - Frame check mismatch flagged
// - Bad terminator sets bits zero and one
// - Status strobe only with valid status
// - Status bit 35 marks pause frames
// - Status bit 34 marks control frames
// - Bits 39..36 mark PFC and addressing
// - All outputs on the receive clock
`timescale 1ns/1ps
`default_nettype none
module rx_mac_client_out (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [rx_mac_pkg::WORD_W-1:0] i_pcs_word,
  input wire logic [rx_mac_pkg::LANES-1:0] i_pcs_ctrl,
  input wire logic i_pcs_valid,
  input wire logic [rx_mac_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [rx_mac_pkg::REG_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [rx_mac_pkg::REG_W-1:0] o_reg_rdata,
  output logic o_irq,
  output logic [rx_mac_pkg::WORD_W-1:0] o_rx_client_word,
  output logic o_rx_client_word_valid,
  output logic o_rx_frame_first,
  output logic o_rx_frame_last,
  output logic [2:0] o_rx_unused_byte_count,
  output logic [rx_mac_pkg::ERR_W-1:0] o_rx_frame_error_vector,
  output logic o_rx_frame_status_strobe,
  output logic [rx_mac_pkg::STS_W-1:0] o_rx_frame_status_word
);
  import rx_mac_pkg::*;

  typedef struct packed {
    fsm_t st;
    logic [WORD_W-1:0] h_word;
    logic h_valid;
    logic h_first;
    logic [2:0] h_empty;
    logic [ERR_W-1:0] p_err;
    logic [STS_W-1:0] p_sts;
    logic [1:0] widx;
    logic [CNT_W-1:0] bcnt;
    logic [15:0] ltype;
    logic [15:0] opcode;
    logic bcast;
    logic mcast;
    logic pt;
    logic [CNT_W-1:0] max_size;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [REG_W-1:0] frames;
    logic [WORD_W-1:0] o_word;
    logic o_valid;
    logic o_first;
    logic o_last;
    logic [2:0] o_empty;
    logic [ERR_W-1:0] o_err;
    logic o_stb;
    logic [STS_W-1:0] o_sts;
    logic o_irq;
    logic [REG_W-1:0] rdata;
  } rx_state_t;

  rx_state_t q;
  rx_state_t d;
  logic [1:0] rst_sync_q;
  logic rst_b;
  logic is_start;
  logic term_fire;
  logic data_fire;
  logic [2:0] n_lanes;
  logic [7:0] term_char;
  logic [CNT_W-1:0] total;
  logic signed [4:0] kept;
  logic [31:0] crc_next;
  logic [ERR_W-1:0] f_err;
  logic [STS_W-1:0] f_sts;
  logic [1:0] events;
  logic [1:0] w1c;

  function automatic logic [2:0] data_lanes(input logic [LANES-1:0] c);
    logic [2:0] n;
    logic hit;
    n = 3'h0;
    hit = 1'b0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (c[i]) begin
        hit = 1'b1;
      end else if (!hit) begin
        n = n + 3'h1;
      end
    end
    return n;
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  assign is_start = i_pcs_valid && i_pcs_ctrl[LANES-1] && (i_pcs_word[WORD_W-1 -: 8] == CHAR_START);
  assign data_fire = (q.st == ST_DATA) && i_pcs_valid && (i_pcs_ctrl == 8'h00);
  assign term_fire = (q.st == ST_DATA) && i_pcs_valid && (i_pcs_ctrl != 8'h00);
  assign n_lanes = data_lanes(i_pcs_ctrl);
  assign term_char = i_pcs_word[(7 - 32'(n_lanes)) * 8 +: 8];
  assign total = q.bcnt + {13'h0, n_lanes};
  assign kept = $signed({2'b00, n_lanes}) - (q.pt ? 5'sh0 : 5'sh4);

  rx_crc32_acc u_crc (
    .i_core_clk(i_core_clk),
    .i_rst_b(rst_b),
    .i_clear(q.st != ST_DATA),
    .i_en(data_fire),
    .i_word(i_pcs_word),
    .i_nbytes(data_fire ? 4'h8 : {1'b0, n_lanes}),
    .o_crc_next(crc_next)
  );

  // Per-frame checks at the terminating word
  always_comb begin
    f_err = '0;
    f_err[ERR_MALF] = term_char != CHAR_TERM;
    f_err[ERR_CRC] = (crc_next != CRC_RESIDUE) || f_err[ERR_MALF];
    f_err[ERR_UNDER] = total < MIN_FRAME;
    f_err[ERR_OVER] = total > q.max_size;
    f_err[ERR_LEN] = (q.ltype < LEN_LIMIT) && (total < q.ltype + HDR_FCS_BYTES);
    f_sts = '0;
    f_sts[ST_CTRL] = q.ltype == TYPE_MAC_CTRL;
    f_sts[ST_PAUSE] = f_sts[ST_CTRL] && (q.opcode == OP_PAUSE);
    f_sts[ST_PFC] = f_sts[ST_CTRL] && (q.opcode == OP_PFC);
    f_sts[ST_BCAST] = q.bcast;
    f_sts[ST_MCAST] = q.mcast && !q.bcast;
    f_sts[ST_UCAST] = !q.mcast;
  end

  always_comb begin
    d = q;
    d.o_valid = 1'b0;
    d.o_first = 1'b0;
    d.o_last = 1'b0;
    d.o_empty = 3'h0;
    d.o_err = '0;
    d.o_stb = 1'b0;
    d.o_sts = '0;
    d.rdata = '0;
    events = 2'h0;
    unique case (q.st)
      ST_IDLE: begin
        if (is_start) begin
          d.st = ST_DATA;
          d.h_valid = 1'b0;
          d.widx = 2'h0;
          d.bcnt = '0;
          d.ltype = '0;
          d.opcode = '0;
        end
      end
      ST_DATA: begin
        if (data_fire) begin
          if (q.h_valid) begin
            d.o_word = q.h_word;
            d.o_valid = 1'b1;
            d.o_first = q.h_first;
          end
          d.h_word = i_pcs_word;
          d.h_valid = 1'b1;
          d.h_first = q.widx == 2'h0;
          d.bcnt = q.bcnt + BYTES_PER_WORD;
          if (q.widx != 2'h2) begin
            d.widx = q.widx + 2'h1;
          end
          if (q.widx == 2'h0) begin
            d.bcast = &i_pcs_word[WORD_W-1:16];
            d.mcast = i_pcs_word[WORD_W-8];
          end
          if (q.widx == 2'h1) begin
            d.ltype = i_pcs_word[31:16];
            d.opcode = i_pcs_word[15:0];
          end
        end else if (term_fire) begin
          d.st = ST_IDLE;
          d.h_valid = 1'b0;
          if (q.h_valid) begin
            d.o_word = q.h_word;
            d.o_valid = 1'b1;
            d.o_first = q.h_first;
            if (kept > 5'sh0) begin
              // Tail lanes of this word still hold data
              d.st = ST_FLUSH;
              d.h_word = i_pcs_word;
              d.h_valid = 1'b1;
              d.h_first = 1'b0;
              d.h_empty = 3'(5'sh8 - kept);
              d.p_err = f_err;
              d.p_sts = f_sts;
            end else begin
              d.o_last = 1'b1;
              d.o_empty = 3'(-kept);
              d.o_err = f_err;
              d.o_stb = 1'b1;
              d.o_sts = f_sts;
              events[INT_FRAME] = 1'b1;
              events[INT_ERROR] = |f_err;
            end
          end
        end
      end
      ST_FLUSH: begin
        d.o_word = q.h_word;
        d.o_valid = 1'b1;
        d.o_last = 1'b1;
        d.o_empty = q.h_empty;
        d.o_err = q.p_err;
        d.o_stb = 1'b1;
        d.o_sts = q.p_sts;
        d.h_valid = 1'b0;
        events[INT_FRAME] = 1'b1;
        events[INT_ERROR] = |q.p_err;
        d.st = ST_IDLE;
        if (is_start) begin
          d.st = ST_DATA;
          d.widx = 2'h0;
          d.bcnt = '0;
          d.ltype = '0;
          d.opcode = '0;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Register port
    w1c = 2'h0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        REG_CTRL: d.pt = i_reg_wdata[CTRL_PASSTHRU];
        REG_MAX_SIZE: d.max_size = i_reg_wdata[CNT_W-1:0];
        REG_INT_STAT: w1c = i_reg_wdata[1:0];
        REG_INT_MASK: d.int_mask = i_reg_wdata[1:0];
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_CTRL: d.rdata = {31'h0, q.pt};
        REG_MAX_SIZE: d.rdata = {16'h0, q.max_size};
        REG_INT_STAT: d.rdata = {30'h0, q.int_stat};
        REG_INT_MASK: d.rdata = {30'h0, q.int_mask};
        REG_FRAMES: d.rdata = q.frames;
        default: d.rdata = '0;
      endcase
    end
    // New events win over a same-cycle clear
    d.int_stat = (q.int_stat & ~w1c) | events;
    if (events[INT_FRAME]) begin
      d.frames = q.frames + 32'h1;
    end
    d.o_irq = |(d.int_stat & d.int_mask);
  end

  // Single receive clock domain
  always_ff @(posedge i_core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.max_size <= MAX_SIZE_RST;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_irq = q.o_irq;
  assign o_rx_client_word = q.o_word;
  assign o_rx_client_word_valid = q.o_valid;
  assign o_rx_frame_first = q.o_first;
  assign o_rx_frame_last = q.o_last;
  assign o_rx_unused_byte_count = q.o_empty;
  assign o_rx_frame_error_vector = q.o_err;
  assign o_rx_frame_status_strobe = q.o_stb;
  assign o_rx_frame_status_word = q.o_sts;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!rst_b);

  a_first_single: assert property (o_rx_frame_first |-> o_rx_client_word_valid ##1 !o_rx_frame_first)
    else $error("first mark not a single valid cycle");
  a_last_with_status: assert property (o_rx_frame_last |-> o_rx_client_word_valid && o_rx_frame_status_strobe)
    else $error("last mark without valid word or status");
  a_empty_only_last: assert property (!o_rx_frame_last |-> o_rx_unused_byte_count == 3'h0)
    else $error("unused count outside last cycle");
  a_error_qualified: assert property (!o_rx_frame_last |-> o_rx_frame_error_vector == 6'h00)
    else $error("error bits outside last cycle");
  a_error_unused: assert property (o_rx_frame_last |-> !o_rx_frame_error_vector[5])
    else $error("unused error bit set");
  a_length_check: assert property (
    (term_fire && q.h_valid && q.ltype < LEN_LIMIT && total < q.ltype + HDR_FCS_BYTES)
    |-> ##[1:2] (o_rx_frame_last && o_rx_frame_error_vector[4]))
    else $error("payload length error missed");
  a_oversize_check: assert property ((term_fire && q.h_valid && total > q.max_size)
    |-> ##[1:2] (o_rx_frame_last && o_rx_frame_error_vector[3]))
    else $error("oversize error missed");
  a_undersize_check: assert property ((term_fire && q.h_valid && total < MIN_FRAME)
    |-> ##[1:2] (o_rx_frame_last && o_rx_frame_error_vector[2]))
    else $error("undersize error missed");
  a_crc_mismatch: assert property ((term_fire && q.h_valid && crc_next != CRC_RESIDUE)
    |-> ##[1:2] (o_rx_frame_last && o_rx_frame_error_vector[1]))
    else $error("crc error missed");
  a_malformed_crc: assert property (o_rx_frame_error_vector[0] |-> o_rx_frame_error_vector[1])
    else $error("malformed without crc error");
  a_status_strobe: assert property (o_rx_frame_status_strobe |-> o_rx_frame_last)
    else $error("status strobe outside last cycle");
  a_pause_control: assert property (o_rx_frame_status_word[35] |-> o_rx_frame_status_word[34])
    else $error("pause frame not marked control");
  a_dest_onehot: assert property (o_rx_frame_status_strobe |-> $onehot(o_rx_frame_status_word[38:36]))
    else $error("destination class not one-hot");

  c_pause_frame: cover property (o_rx_frame_status_strobe && o_rx_frame_status_word[35]);
  c_flush_last: cover property (q.st == ST_FLUSH ##1 o_rx_frame_last);
  c_error_frame: cover property (o_rx_frame_last && o_rx_frame_error_vector != 6'h00);
  c_passthru_last: cover property (q.pt && o_rx_frame_last && !o_rx_frame_error_vector[1]);
endmodule
`default_nettype wire

// ---- logic/rx_mac_pkg.sv ----
// Constants for the receive MAC client output stage.
// Assumes one core clock; no other package is needed.
package rx_mac_pkg;
  localparam int WORD_W = 64;
  localparam int LANES = 8;
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam int ERR_W = 6;
  localparam int STS_W = 40;
  localparam int CNT_W = 16;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MAX_SIZE = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_FRAMES = 8'h10;
  localparam int CTRL_PASSTHRU = 0;
  localparam logic [15:0] MAX_SIZE_RST = 16'h05ee;
  localparam int INT_FRAME = 0;
  localparam int INT_ERROR = 1;
  // Link control characters
  localparam logic [7:0] CHAR_START = 8'hfb;
  localparam logic [7:0] CHAR_TERM = 8'hfd;
  // Frame checks
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] LEN_LIMIT = 16'h0600;
  localparam logic [15:0] HDR_FCS_BYTES = 16'h0012;
  localparam logic [15:0] TYPE_MAC_CTRL = 16'h8808;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [15:0] OP_PFC = 16'h0101;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0008;
  localparam logic [3:0] FCS_BYTES = 4'h4;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  // Error vector bits
  localparam int ERR_LEN = 4;
  localparam int ERR_OVER = 3;
  localparam int ERR_UNDER = 2;
  localparam int ERR_CRC = 1;
  localparam int ERR_MALF = 0;
  // Status word bits
  localparam int ST_PFC = 39;
  localparam int ST_UCAST = 38;
  localparam int ST_MCAST = 37;
  localparam int ST_BCAST = 36;
  localparam int ST_PAUSE = 35;
  localparam int ST_CTRL = 34;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_FLUSH = 2'b11
  } fsm_t;
endpackage

// ---- tb/rx_client_model.sv ----
// Client-side sink for received frames: collects bytes, error and status per frame.
// Assumes registered design outputs on the core clock and no backpressure.
`timescale 1ns/1ps
`default_nettype none
module rx_client_model (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [rx_mac_pkg::WORD_W-1:0] i_word,
  input wire logic i_valid,
  input wire logic i_first,
  input wire logic i_last,
  input wire logic [2:0] i_empty,
  input wire logic [rx_mac_pkg::ERR_W-1:0] i_err,
  input wire logic i_sts_strobe,
  input wire logic [rx_mac_pkg::STS_W-1:0] i_sts
);
  import rx_mac_pkg::*;
  logic [7:0] got[$];
  int frames = 0;
  int firsts = 0;
  logic [ERR_W-1:0] err = '0;
  logic [STS_W-1:0] sts = '0;
  // Everything sampled on the core clock only
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      got.delete();
    end else if (i_valid) begin
      if (i_first) begin
        got.delete();
        firsts++;
      end
      for (int k = 7; k >= 0; k--) begin
        if (!i_last || k >= i_empty) begin
          got.push_back(i_word[8*k +: 8]);
        end
      end
      // Error, empty and status taken only at the last word
      if (i_last) begin
        frames++;
        err = i_err;
        sts = i_sts_strobe ? i_sts : '0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Testbench: drives decoded lane words and register accesses, checks delivered frames.
// Assumes the client model on the output side; the design has no parameters.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rx_mac_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [WORD_W-1:0] i_pcs_word = '0;
  logic [LANES-1:0] i_pcs_ctrl = '1;
  logic i_pcs_valid = 1'b0;
  logic [ADDR_W-1:0] i_reg_addr = '0;
  logic [REG_W-1:0] i_reg_wdata = '0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [REG_W-1:0] o_reg_rdata;
  logic o_irq;
  logic [WORD_W-1:0] o_rx_client_word;
  logic o_rx_client_word_valid;
  logic o_rx_frame_first;
  logic o_rx_frame_last;
  logic [2:0] o_rx_unused_byte_count;
  logic [ERR_W-1:0] o_rx_frame_error_vector;
  logic o_rx_frame_status_strobe;
  logic [STS_W-1:0] o_rx_frame_status_word;
  int failures = 0;
  int comparisons = 0;
  int nframes = 0;
  logic pt = 1'b0;
  logic [7:0] fr[$];
  localparam logic [47:0] UC = 48'h020000000001;
  localparam logic [39:0] UCS = {8'h40, 32'h0};
  localparam logic [63:0] IDLE = {8{8'h07}};

  rx_mac_client_out u_rx_mac_client_out (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_pcs_word(i_pcs_word), .i_pcs_ctrl(i_pcs_ctrl),
    .i_pcs_valid(i_pcs_valid), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq), .o_rx_client_word(o_rx_client_word),
    .o_rx_client_word_valid(o_rx_client_word_valid), .o_rx_frame_first(o_rx_frame_first),
    .o_rx_frame_last(o_rx_frame_last), .o_rx_unused_byte_count(o_rx_unused_byte_count),
    .o_rx_frame_error_vector(o_rx_frame_error_vector), .o_rx_frame_status_strobe(o_rx_frame_status_strobe),
    .o_rx_frame_status_word(o_rx_frame_status_word)
  );

  rx_client_model u_rx_client_model (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_word(o_rx_client_word), .i_valid(o_rx_client_word_valid),
    .i_first(o_rx_frame_first), .i_last(o_rx_frame_last), .i_empty(o_rx_unused_byte_count),
    .i_err(o_rx_frame_error_vector), .i_sts_strobe(o_rx_frame_status_strobe), .i_sts(o_rx_frame_status_word)
  );

  always #4 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, exp);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(o_irq, exp);
  endtask

  task automatic drv(input logic [63:0] w, input logic [7:0] c);
    @(posedge i_core_clk);
    i_pcs_word <= w;
    i_pcs_ctrl <= c;
    i_pcs_valid <= 1'b1;
  endtask

  // Header, filler, then reflected CRC sent low byte first
  task automatic build(input int n, input logic [47:0] da, input logic [15:0] ty, input logic [15:0] op);
    logic [31:0] c;
    fr.delete();
    for (int i = 0; i < 6; i++) fr.push_back(da[47-8*i -: 8]);
    for (int i = 0; i < 6; i++) fr.push_back(8'h10 + 8'(i));
    fr.push_back(ty[15:8]);
    fr.push_back(ty[7:0]);
    fr.push_back(op[15:8]);
    fr.push_back(op[7:0]);
    while (fr.size() < n - 4) fr.push_back(8'(fr.size()));
    c = CRC_INIT;
    foreach (fr[i]) begin
      c ^= {24'h0, fr[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    c = ~c;
    for (int i = 0; i < 4; i++) fr.push_back(c[8*i +: 8]);
  endtask

  task automatic send(input logic [7:0] term, input logic [5:0] e, input logic [39:0] s);
    logic [63:0] w;
    int n;
    int f0;
    int len;
    n = fr.size();
    f0 = u_rx_client_model.frames;
    len = pt ? n : n - 4;
    drv({CHAR_START, 56'h0}, 8'h80);
    for (int i = 0; i < n / 8; i++) begin
      for (int j = 0; j < 8; j++) w[63-8*j -: 8] = fr[8*i+j];
      drv(w, 8'h00);
    end
    w = IDLE;
    for (int j = 0; j < n % 8; j++) w[63-8*j -: 8] = fr[8*(n/8)+j];
    w[63-8*(n%8) -: 8] = term;
    drv(w, 8'hff >> (n % 8));
    drv(IDLE, 8'hff);
    for (int t = 0; t < 20 && u_rx_client_model.frames == f0; t++) @(posedge i_core_clk);
    nframes++;
    chk(u_rx_client_model.frames, f0 + 1);
    chk(u_rx_client_model.firsts, u_rx_client_model.frames);
    chk(u_rx_client_model.got.size(), len);
    if (u_rx_client_model.got.size() == len) begin
      for (int i = 0; i < len; i++) chk(u_rx_client_model.got[i], fr[i]);
    end
    chk(u_rx_client_model.err, e);
    chk(u_rx_client_model.sts, s);
  endtask

  initial begin
    #100000;
    failures++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    rd(REG_CTRL, 32'h0);
    rd(REG_MAX_SIZE, {16'h0, MAX_SIZE_RST});
    rd(REG_INT_STAT, 32'h0);
    rd(REG_INT_MASK, 32'h0);
    rd(REG_FRAMES, 32'h0);
    wr(8'h14, 32'h5);
    rd(8'h14, 32'h0);
    build(64, UC, 16'h0800, 16'h0);
    send(CHAR_TERM, 6'h00, UCS);
    chk(o_irq, 1'b0);
    rd(REG_INT_STAT, 32'h1);
    wr(REG_INT_MASK, 32'h3);
    irq_is(1'b1);
    wr(REG_INT_STAT, 32'h1);
    irq_is(1'b0);
    // Every empty-lane count, data ends in each lane
    for (int n = 64; n < 72; n++) begin
      build(n, UC, 16'h0800, 16'h0);
      send(CHAR_TERM, 6'h00, UCS);
    end
    build(63, UC, 16'h0800, 16'h0);
    send(CHAR_TERM, 6'h04, UCS);
    build(64, UC, 16'h0030, 16'h0);
    send(CHAR_TERM, 6'h10, UCS);
    build(64, UC, 16'h002e, 16'h0);
    send(CHAR_TERM, 6'h00, UCS);
    build(64, UC, 16'h0800, 16'h0);
    fr[20] ^= 8'h01;
    send(CHAR_TERM, 6'h02, UCS);
    build(64, UC, 16'h0800, 16'h0);
    send(8'h07, 6'h03, UCS);
    wr(REG_MAX_SIZE, 32'h40);
    build(65, UC, 16'h0800, 16'h0);
    send(CHAR_TERM, 6'h08, UCS);
    build(64, UC, 16'h0800, 16'h0);
    send(CHAR_TERM, 6'h00, UCS);
    wr(REG_MAX_SIZE, {16'h0, MAX_SIZE_RST});
    build(64, 48'hffffffffffff, TYPE_MAC_CTRL, OP_PAUSE);
    send(CHAR_TERM, 6'h00, {8'h1c, 32'h0});
    build(64, 48'h0180c2000001, TYPE_MAC_CTRL, OP_PFC);
    send(CHAR_TERM, 6'h00, {8'ha4, 32'h0});
    wr(REG_CTRL, 32'h1);
    pt = 1'b1;
    build(64, UC, 16'h0800, 16'h0);
    send(CHAR_TERM, 6'h00, UCS);
    build(69, UC, 16'h0800, 16'h0);
    send(CHAR_TERM, 6'h00, UCS);
    wr(REG_CTRL, 32'h0);
    pt = 1'b0;
    rd(REG_INT_STAT, 32'h3);
    irq_is(1'b1);
    wr(REG_INT_MASK, 32'h1);
    wr(REG_INT_STAT, 32'h1);
    irq_is(1'b0);
    rd(REG_INT_STAT, 32'h2);
    wr(REG_INT_STAT, 32'h2);
    rd(REG_INT_STAT, 32'h0);
    wr(REG_FRAMES, 32'h0);
    rd(REG_FRAMES, 32'(nframes));
    test_done();
  end
endmodule
`default_nettype wire
